/* File: design/ulmd_defs.svh */
// Purpose: Shared constants of the USB link mode detector
// Assumes: 50 MHz system clock
// Notes:   Register offsets, field positions, reset values and timing
`ifndef ULMD_DEFS_SVH
`define ULMD_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define ULMD_CLK_MHZ        50
`define ULMD_T_ATTACH_US    3
`define ULMD_T_RESET_US     3
`define ULMD_T_CHIRP_MIN_US 18
`define ULMD_T_CHIRP_MAX_US 128
`define ULMD_T_DISC_US      20000
// Least times round up, longest times round down
`define ULMD_CYC_MIN(us)    ((us) * `ULMD_CLK_MHZ)
`define ULMD_CYC_MAX(us)    ((us) * `ULMD_CLK_MHZ)

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ULMD_OFS_STATUS     8'h00
`define ULMD_OFS_IRQ_STAT   8'h04
`define ULMD_OFS_IRQ_MASK   8'h08
`define ULMD_OFS_CTRL       8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ULMD_IRQ_W          5
`define ULMD_EV_ATTACH      0
`define ULMD_EV_DETACH      1
`define ULMD_EV_HS_ENTER    2
`define ULMD_EV_HS_EXIT     3
`define ULMD_EV_CHIRP_OK    4
`define ULMD_CTRL_EQ_OFF    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ULMD_RST_IRQ_MASK   5'h00
`define ULMD_RST_CTRL       1'b0
`define ULMD_RST_GAIN       2'h3

`endif

/* File: design/ulmd_pkg.sv */
// Purpose: Types of the USB link mode detector
// Assumes: Nothing beyond the defs header
// Notes:   States and speeds only; numbers live in ulmd_defs.svh
package ulmd_pkg;

  // Link state machine
  typedef enum logic [2:0] {
    ULMD_ST_DISABLED = 3'b000,
    ULMD_ST_UNCONN   = 3'b001,
    ULMD_ST_FIXTURE  = 3'b010,
    ULMD_ST_FSLS     = 3'b011,
    ULMD_ST_RESET    = 3'b100,
    ULMD_ST_HS       = 3'b101
  } ulmd_state_t;

  // Detected connection speed
  typedef enum logic [1:0] {
    ULMD_SPD_NONE = 2'b00,
    ULMD_SPD_LS   = 2'b01,
    ULMD_SPD_FS   = 2'b10,
    ULMD_SPD_HS   = 2'b11
  } ulmd_speed_t;

endpackage

/* File: design/ulmd_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are levels, slow against the clock
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module ulmd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;  // First stage, may go metastable

  // Two stages, nothing reads the first one but the second
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // ulmd_sync

`default_nettype wire

/* File: design/ulmd_chirp.sv */
// Purpose: Chirp J / chirp K pair checker of the high-speed handshake
// Assumes: Line levels already synchronised; armed only during bus reset
// Notes:   Each chirp length is judged when the line leaves that chirp
`timescale 1ns/1ps
`default_nettype none

module ulmd_chirp #(
  parameter int MIN_CYC = 900,
  parameter int MAX_CYC = 6400
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // Line
  input  wire logic i_arm,       // High while the bus is in reset
  input  wire logic i_chirp_j,   // Positive line alone high
  input  wire logic i_chirp_k,   // Negative line alone high
  // Result
  output logic      o_pair_ok,   // Sticky until disarmed
  output logic      o_pair_pulse // One cycle when the first pair completes
);

  logic [1:0]  lvl_r;    // Level of the running segment {k, j}
  logic [15:0] cnt_r;    // Length of the running segment, saturating
  logic        j_ok_r;   // Last segment was a good chirp J
  logic        in_rng;   // Running segment within the chirp window
  logic        change;   // Line just left the running segment

  assign in_rng = (cnt_r >= 16'(MIN_CYC)) && (cnt_r <= 16'(MAX_CYC));
  assign change = ({i_chirp_k, i_chirp_j} != lvl_r);

  // Segment length counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_arm) begin
      lvl_r <= 2'h0;
      cnt_r <= 16'h0000;
    end else if (change) begin
      lvl_r <= {i_chirp_k, i_chirp_j};
      cnt_r <= 16'h0001;
    end else if (cnt_r != 16'hFFFF) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // A good J followed by a good K makes the handshake
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_arm) begin
      j_ok_r       <= 1'b0;
      o_pair_ok    <= 1'b0;
      o_pair_pulse <= 1'b0;
    end else begin
      o_pair_pulse <= 1'b0;
      if (change) begin
        j_ok_r <= (lvl_r == 2'b01) && in_rng;
        if ((lvl_r == 2'b10) && in_rng && j_ok_r && !o_pair_ok) begin
          o_pair_ok    <= 1'b1;
          o_pair_pulse <= 1'b1;
        end
      end
    end
  end

endmodule // ulmd_chirp

`default_nettype wire

/* File: design/ulmd_top.sv */
// Purpose: Link mode detector of a pass-through USB 2.0 signal conditioner
// Assumes: Line levels, squelch, fixture, test-packet and high-speed
//          disconnect arrive as digital levels from analog comparators
// Notes:   Registers over AHB-Lite, one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
`include "ulmd_defs.svh"

module ulmd_top #(
  parameter int P_CHIRP_MAX_CYC = `ULMD_CYC_MAX(`ULMD_T_CHIRP_MAX_US),
  parameter int P_DISC_CYC      = `ULMD_CYC_MIN(`ULMD_T_DISC_US)
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Line comparators of both ports
  input  wire logic        i_port_a_pos,
  input  wire logic        i_port_a_neg,
  input  wire logic        i_port_b_pos,
  input  wire logic        i_port_b_neg,
  input  wire logic        i_squelch,
  input  wire logic        i_hs_disconnect,
  input  wire logic        i_fixture_detect,
  input  wire logic        i_test_packet,
  // Device pins
  input  wire logic        i_chip_enable_n,
  input  wire logic [2:0]  i_gain_select,
  output logic             o_attach_flag,
  output logic             o_high_speed_flag,
  output logic             o_core_regulator_out,
  output logic             o_eq_enable,
  output logic [1:0]       o_eq_level,
  // Interrupt
  output logic             o_irq,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  output logic             o_hresp
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [19:0] ATTACH_CYC = 20'(`ULMD_CYC_MIN(`ULMD_T_ATTACH_US));
  localparam logic [19:0] RESET_CYC  = 20'(`ULMD_CYC_MIN(`ULMD_T_RESET_US));
  localparam int          CHIRP_MIN  = `ULMD_CYC_MIN(`ULMD_T_CHIRP_MIN_US);

  // Thermometer code of the gain comparators to an EQ level
  function automatic logic [1:0] gain_decode(input logic [2:0] t);
    case (t)
      3'b000:  gain_decode = 2'h0;
      3'b001:  gain_decode = 2'h1;
      3'b011:  gain_decode = 2'h2;
      default: gain_decode = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [11:0] pins_s;  // Synchronised pin levels
  ulmd_sync #(.W(12)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_gain_select, i_chip_enable_n, i_test_packet,
                 i_fixture_detect, i_hs_disconnect, i_squelch,
                 i_port_b_neg, i_port_b_pos, i_port_a_neg, i_port_a_pos}),
    .o_sync    (pins_s)
  );

  logic       dp, dm;      // Ports merged, so orientation does not matter
  logic       line_j, line_k, line_se0;
  logic       squelch_s, hs_disc_s, fixture_s, test_pkt_s, enable_s;
  logic [2:0] gain_s;
  logic [1:0] settle_r;  // Sync stages loaded with real pin levels yet

  // The synchronisers reset to zero, which reads as enabled; holding the
  // block disabled for two edges avoids a false enable and gain latch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      settle_r <= 2'b00;
    end else begin
      settle_r <= {settle_r[0], 1'b1};
    end
  end

  assign dp         = pins_s[0] | pins_s[2];
  assign dm         = pins_s[1] | pins_s[3];
  assign squelch_s  = pins_s[4];
  assign hs_disc_s  = pins_s[5];
  assign fixture_s  = pins_s[6];
  assign test_pkt_s = pins_s[7];
  assign enable_s   = !pins_s[8] && settle_r[1];
  assign gain_s     = pins_s[11:9];
  assign line_j     = dp & !dm;
  assign line_k     = dm & !dp;
  assign line_se0   = !dp & !dm;

  // ----------------------------------------------------------------------
  // Line state duration
  // ----------------------------------------------------------------------
  logic [1:0]  cls_r;   // Last class {k, j}, 00 is SE0
  logic [19:0] dur_r;   // Cycles in that class, saturating

  // Counts how long the merged line has kept its class
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cls_r <= 2'h0;
      dur_r <= 20'h0_0000;
    end else if ({line_k, line_j} != cls_r) begin
      cls_r <= {line_k, line_j};
      dur_r <= 20'h0_0001;
    end else if (dur_r != 20'hF_FFFF) begin
      dur_r <= dur_r + 20'h0_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------------
  ulmd_pkg::ulmd_state_t state_r, state_nxt;
  ulmd_pkg::ulmd_speed_t speed_r;
  logic                  pair_ok, pair_pulse;
  logic                  armed;

  assign armed = (state_r == ulmd_pkg::ULMD_ST_RESET);

  ulmd_chirp #(.MIN_CYC(CHIRP_MIN), .MAX_CYC(P_CHIRP_MAX_CYC)) u_chirp (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_arm        (armed),
    .i_chirp_j    (line_j),
    .i_chirp_k    (line_k),
    .o_pair_ok    (pair_ok),
    .o_pair_pulse (pair_pulse)
  );

  // Next state; disable overrides everything
  always_comb begin
    state_nxt = state_r;
    if (!enable_s) begin
      state_nxt = ulmd_pkg::ULMD_ST_DISABLED;
    end else begin
      case (state_r)
        ulmd_pkg::ULMD_ST_DISABLED: begin
          state_nxt = ulmd_pkg::ULMD_ST_UNCONN;
        end
        ulmd_pkg::ULMD_ST_UNCONN: begin
          if (fixture_s) begin
            state_nxt = ulmd_pkg::ULMD_ST_FIXTURE;
          end else if (!line_se0 && dur_r >= ATTACH_CYC) begin
            state_nxt = ulmd_pkg::ULMD_ST_FSLS;
          end
        end
        ulmd_pkg::ULMD_ST_FIXTURE: begin
          if (test_pkt_s) begin
            state_nxt = ulmd_pkg::ULMD_ST_HS;
          end else if (!fixture_s) begin
            state_nxt = ulmd_pkg::ULMD_ST_UNCONN;
          end
        end
        ulmd_pkg::ULMD_ST_FSLS: begin
          // Short SE0 is end of packet; a longer one is bus reset
          if (line_se0 && dur_r >= RESET_CYC) begin
            state_nxt = ulmd_pkg::ULMD_ST_RESET;
          end
        end
        ulmd_pkg::ULMD_ST_RESET: begin
          if (pair_ok && squelch_s) begin
            state_nxt = ulmd_pkg::ULMD_ST_HS;
          end else if (line_se0 && dur_r >= 20'(P_DISC_CYC)) begin
            state_nxt = ulmd_pkg::ULMD_ST_UNCONN;
          end else if (!pair_ok && !line_se0 &&
                       dur_r > 20'(P_CHIRP_MAX_CYC)) begin
            // Idle longer than any chirp: no handshake, stays full/low
            state_nxt = ulmd_pkg::ULMD_ST_FSLS;
          end
        end
        ulmd_pkg::ULMD_ST_HS: begin
          if (hs_disc_s) begin
            state_nxt = ulmd_pkg::ULMD_ST_UNCONN;
          end else if (line_j && dur_r >= ATTACH_CYC) begin
            // Peer reverted to full-speed idle: suspend
            state_nxt = ulmd_pkg::ULMD_ST_FSLS;
          end
        end
        default: state_nxt = ulmd_pkg::ULMD_ST_DISABLED;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_r <= ulmd_pkg::ULMD_ST_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Speed: negative line pull-up is low speed, positive is full speed
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      speed_r <= ulmd_pkg::ULMD_SPD_NONE;
    end else begin
      case (state_nxt)
        ulmd_pkg::ULMD_ST_HS:
          speed_r <= ulmd_pkg::ULMD_SPD_HS;
        ulmd_pkg::ULMD_ST_FSLS: begin
          if (state_r != ulmd_pkg::ULMD_ST_FSLS) begin
            speed_r <= line_k ? ulmd_pkg::ULMD_SPD_LS
                              : ulmd_pkg::ULMD_SPD_FS;
          end
        end
        ulmd_pkg::ULMD_ST_RESET:
          speed_r <= speed_r;
        default:
          speed_r <= ulmd_pkg::ULMD_SPD_NONE;
      endcase
    end
  end

  // Gain level caught only when leaving disable; pin ignored after
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_eq_level <= `ULMD_RST_GAIN;
    end else if (state_r == ulmd_pkg::ULMD_ST_DISABLED &&
                 state_nxt == ulmd_pkg::ULMD_ST_UNCONN) begin
      o_eq_level <= gain_decode(gain_s);
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  logic ctrl_eq_off_r;  // Software override that holds compensation off
  logic nxt_attach, nxt_hs;

  assign nxt_attach = (state_nxt == ulmd_pkg::ULMD_ST_FSLS)  ||
                      (state_nxt == ulmd_pkg::ULMD_ST_RESET) ||
                      (state_nxt == ulmd_pkg::ULMD_ST_HS);
  assign nxt_hs     = (state_nxt == ulmd_pkg::ULMD_ST_HS);

  // Flags and enables follow the next state, so they change together, except o_eq_enable on a ctrl_eq_off_r write
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_attach_flag        <= 1'b0;
      o_high_speed_flag    <= 1'b0;
      o_core_regulator_out <= 1'b0;
      o_eq_enable          <= 1'b0;
    end else begin
      o_attach_flag        <= nxt_attach;
      o_high_speed_flag    <= nxt_hs;
      o_core_regulator_out <= nxt_hs;
      o_eq_enable          <= nxt_hs && !ctrl_eq_off_r;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  logic [`ULMD_IRQ_W-1:0] ev, irq_stat_r, irq_mask_r;
  logic                   rd_clr;  // Read of the interrupt status register

  assign ev[`ULMD_EV_ATTACH]   = nxt_attach & !o_attach_flag;
  assign ev[`ULMD_EV_DETACH]   = !nxt_attach & o_attach_flag;
  assign ev[`ULMD_EV_HS_ENTER] = nxt_hs & !o_high_speed_flag;
  assign ev[`ULMD_EV_HS_EXIT]  = !nxt_hs & o_high_speed_flag;
  assign ev[`ULMD_EV_CHIRP_OK] = pair_pulse;

  // Sticky status; a new event wins over the clearing read
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_stat_r <= '0;
    end else if (rd_clr) begin
      irq_stat_r <= ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  // Level interrupt
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic       pend_r;   // Data phase in progress
  logic       wr_r;     // Pending transfer is a write
  logic [7:0] addr_r;   // Pending byte address, word aligned
  logic       ap_take;

  // Only NONSEQ/SEQ with the bus ready opens a transfer
  assign ap_take = i_hsel && i_htrans[1] && i_hready;
  assign rd_clr  = pend_r && !wr_r && (addr_r == `ULMD_OFS_IRQ_STAT);

  // Address phase capture and one wait state in the data phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pend_r      <= 1'b0;
      wr_r        <= 1'b0;
      addr_r      <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else if (pend_r) begin
      pend_r      <= 1'b0;
      o_hreadyout <= 1'b1;
    end else if (ap_take) begin
      pend_r      <= 1'b1;
      wr_r        <= i_hwrite;
      addr_r      <= {i_haddr[7:2], 2'b00};
      o_hreadyout <= 1'b0;
    end
  end

  // Writable registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_mask_r    <= `ULMD_RST_IRQ_MASK;
      ctrl_eq_off_r <= `ULMD_RST_CTRL;
    end else if (pend_r && wr_r) begin
      if (addr_r == `ULMD_OFS_IRQ_MASK) begin
        irq_mask_r <= i_hwdata[`ULMD_IRQ_W-1:0];
      end
      if (addr_r == `ULMD_OFS_CTRL) begin
        ctrl_eq_off_r <= i_hwdata[`ULMD_CTRL_EQ_OFF];
      end
    end
  end

  // Read data, loaded at the end of the wait state; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (pend_r && !wr_r) begin
      case (addr_r)
        `ULMD_OFS_STATUS:
          o_hrdata <= {22'h00_0000, o_eq_level, speed_r, state_r,
                       o_core_regulator_out, o_high_speed_flag, o_attach_flag};
        `ULMD_OFS_IRQ_STAT:
          o_hrdata <= {27'h000_0000, irq_stat_r};
        `ULMD_OFS_IRQ_MASK:
          o_hrdata <= {27'h000_0000, irq_mask_r};
        `ULMD_OFS_CTRL:
          o_hrdata <= {31'h0000_0000, ctrl_eq_off_r};
        default:
          o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // ulmd_top

`default_nettype wire

/* File: verification/ulmd_chk.sv */
// Purpose: Port-level checks of the link mode detector
// Assumes: Two sync stages and one output stage of lag
// Notes:   Causes are held for many cycles, so lag slack is safe
`timescale 1ns/1ps
`default_nettype none
module ulmd_chk (
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  // Line and detector levels
  input wire logic       i_port_a_pos,
  input wire logic       i_port_a_neg,
  input wire logic       i_port_b_pos,
  input wire logic       i_port_b_neg,
  input wire logic       i_squelch,
  input wire logic       i_hs_disconnect,
  input wire logic       i_test_packet,
  input wire logic       i_chip_enable_n,
  // Outputs under check
  input wire logic       o_attach_flag,
  input wire logic       o_high_speed_flag,
  input wire logic       o_core_regulator_out,
  input wire logic       o_eq_enable,
  input wire logic [1:0] o_eq_level,
  input wire logic       o_irq,
  input wire logic       o_hreadyout,
  input wire logic       o_hresp
);
  // ------
  // Causes
  // ------
  logic att_cause;  // Any pull-up, or the fixture path ending
  logic hs_cause;   // Squelch or test pattern
  assign att_cause = i_port_a_pos | i_port_a_neg | i_port_b_pos | i_port_b_neg | i_test_packet;
  assign hs_cause  = i_squelch | i_test_packet;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  attach_rise_a: assert property ($rose(o_attach_flag) |-> $past(att_cause, 3))
    else $error("attach flag rose without a pull-up");
  hs_rise_a: assert property ($rose(o_high_speed_flag) |-> $past(hs_cause, 3))
    else $error("high speed flag rose without cause");
  hs_drop_a: assert property (i_hs_disconnect [*6] |-> !o_high_speed_flag)
    else $error("high speed flag kept through disconnect");
  eq_hold_a: assert property ((!i_chip_enable_n) [*8] |=> $stable(o_eq_level))
    else $error("eq level moved while enabled");
  eq_hs_a: assert property (o_eq_enable |-> o_high_speed_flag)
    else $error("compensation on outside high speed");
  hs_attach_a: assert property (o_high_speed_flag |-> o_attach_flag)
    else $error("high speed without attach");
  off_flags_a: assert property (i_chip_enable_n [*6] |->
    !(o_attach_flag | o_high_speed_flag | o_eq_enable | o_core_regulator_out))
    else $error("indication while disabled");
  reg_hs_a: assert property (o_core_regulator_out == o_high_speed_flag)
    else $error("regulator differs from high speed");
  wait_one_a: assert property ($fell(o_hreadyout) |=> o_hreadyout && !o_hresp)
    else $error("bus wait not one cycle");
  cover property ($rose(o_high_speed_flag));
  cover property ($fell(o_attach_flag));
  cover property ($rose(o_irq));
endmodule // ulmd_chk
bind ulmd_top ulmd_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_port_a_pos(i_port_a_pos),
  .i_port_a_neg(i_port_a_neg), .i_port_b_pos(i_port_b_pos), .i_port_b_neg(i_port_b_neg),
  .i_squelch(i_squelch), .i_hs_disconnect(i_hs_disconnect), .i_test_packet(i_test_packet),
  .i_chip_enable_n(i_chip_enable_n), .o_attach_flag(o_attach_flag),
  .o_high_speed_flag(o_high_speed_flag), .o_core_regulator_out(o_core_regulator_out),
  .o_eq_enable(o_eq_enable), .o_eq_level(o_eq_level), .o_irq(o_irq),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));
`default_nettype wire

/* File: verification/ulmd_peer.sv */
// Purpose: USB peer and connector model on either port
// Assumes: Released lines fall to the pull-downs
// Notes:   Chirp lengths are chosen by the bench per call
`timescale 1ns/1ps
`default_nettype none
module ulmd_peer (
  // Clock
  input  wire logic i_clk_sys,
  // Lines of both ports
  output logic      o_a_pos,
  output logic      o_a_neg,
  output logic      o_b_pos,
  output logic      o_b_neg,
  // Detector levels
  output logic      o_squelch,
  output logic      o_hs_disc,
  output logic      o_fixture,
  output logic      o_test_pkt
);
  initial begin
    {o_a_pos, o_a_neg, o_b_pos, o_b_neg} = 4'h0;
    {o_squelch, o_hs_disc, o_fixture, o_test_pkt} = 4'h0;
  end
  // Drive one port; the far one is released, as no peer sits there
  task automatic line(input logic side, input logic p, input logic n, input int cyc);
    @(posedge i_clk_sys);
    {o_a_pos, o_a_neg} <= side ? 2'h0 : {p, n};
    {o_b_pos, o_b_neg} <= side ? {p, n} : 2'h0;
    repeat (cyc) @(posedge i_clk_sys);
  endtask
  // Detector levels: squelch, disconnect, fixture, test pattern
  task automatic ctl(input logic [3:0] v, input int cyc);
    @(posedge i_clk_sys);
    {o_squelch, o_hs_disc, o_fixture, o_test_pkt} <= v;
    repeat (cyc) @(posedge i_clk_sys);
  endtask
endmodule // ulmd_peer
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench of the link mode detector
// Assumes: One bus wait state; chirp limit 1200, disconnect 2000
// Notes:   Peer drives lines; bench drives pins and the bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst_n = 0, ce_n = 1, hsel = 0, hwr = 0;
  logic [2:0]  gsel = 3'h7;
  logic [1:0]  htr = 2'h0;
  logic [31:0] hadr = 32'h0000_0000, hwd = 32'h0000_0000, rd, hrd;
  logic        att, hs, core_regulator_out, eqen, irq, hrdy, hresp, ap, an, bp, bn, sq, dc, fx, tp;
  logic [1:0]  eql;
  int          num_errors = 0, compares = 0;
  always #10 clk = ~clk;
  ulmd_peer u_peer (.i_clk_sys(clk), .o_a_pos(ap), .o_a_neg(an), .o_b_pos(bp), .o_b_neg(bn),
    .o_squelch(sq), .o_hs_disc(dc), .o_fixture(fx), .o_test_pkt(tp));
  ulmd_top #(.P_CHIRP_MAX_CYC(1200), .P_DISC_CYC(2000)) u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_port_a_pos(ap), .i_port_a_neg(an), .i_port_b_pos(bp),
    .i_port_b_neg(bn), .i_squelch(sq), .i_hs_disconnect(dc), .i_fixture_detect(fx),
    .i_test_packet(tp), .i_chip_enable_n(ce_n), .i_gain_select(gsel), .o_attach_flag(att),
    .o_high_speed_flag(hs), .o_core_regulator_out(core_regulator_out), .o_eq_enable(eqen), .o_eq_level(eql),
    .o_irq(irq), .i_hsel(hsel), .i_haddr(hadr), .i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2),
    .i_hwdata(hwd), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrd), .o_hresp(hresp));
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pins(input string w, input logic [3:0] e);
    chk(w, {28'h0, e}, {28'h0, eqen, core_regulator_out, hs, att});
  endtask
  // Single word transfer; waits on ready with a bound
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    {hsel, htr, hwr, hadr} <= {1'b1, 2'h2, wr, 24'h0, a};
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin num_errors++; close_out(); end
    {hsel, htr, hwd} <= {1'b0, 2'h0, wd};
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 100);
    rd = hrd;
    if (hrdy !== 1'b1) begin num_errors++; close_out(); end
  endtask
  task automatic t_regs();
    ahb(0, 8'h08, 0);
    chk("mask rst", 32'h0000_0000, rd);
    ahb(0, 8'h0C, 0);
    chk("ctrl rst", 32'h0000_0000, rd);
    ahb(1, 8'h08, 32'h0000_0001);
    ahb(0, 8'h08, 0);
    chk("mask", 32'h0000_0001, rd);
    ahb(0, 8'h10, 0);
    chk("unmapped", 32'h0000_0000, rd);
  endtask
  task automatic t_gain();
    logic [2:0] g [5] = '{3'h0, 3'h1, 3'h7, 3'h5, 3'h3};
    logic [1:0] l [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
    for (int i = 0; i < 5; i++) begin
      {ce_n, gsel} <= {1'b1, g[i]};
      cyc(8);
      pins("off", 4'h0);
      ce_n <= 1'b0;
      cyc(8);
      chk("eq lvl", {30'h0, l[i]}, {30'h0, eql});
      gsel <= ~g[i];
      cyc(8);
      chk("eq hold", {30'h0, l[i]}, {30'h0, eql});
    end
  endtask
  task automatic t_att(input logic s, input logic p, input logic n, input logic [1:0] spd);
    u_peer.line(s, p, n, 170);
    pins("attach", 4'h1);
    ahb(0, 8'h00, 0);
    chk("speed", {30'h0, spd}, {30'h0, rd[7:6]});
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    ahb(0, 8'h04, 0);
    chk("ev attach", 32'h0000_0001, rd);
    u_peer.line(s, 0, 0, 2400);
    pins("detach", 4'h0);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    ahb(0, 8'h04, 0);
    chk("ev detach", 32'h0000_0002, rd);
  endtask
  task automatic t_hs();
    u_peer.line(1, 1, 0, 170);
    u_peer.line(1, 0, 0, 170);
    u_peer.line(1, 1, 0, 500);
    u_peer.line(1, 0, 1, 500);
    u_peer.ctl(4'h8, 20);
    pins("short chirp", 4'h1);
    u_peer.ctl(4'h0, 1);
    u_peer.line(1, 1, 0, 1000);
    u_peer.line(1, 0, 1, 1000);
    u_peer.line(1, 0, 0, 10);
    u_peer.ctl(4'h8, 20);
    pins("hs", 4'hF);
    chk("hs lvl", 32'h0000_0002, {30'h0, eql});
    ahb(0, 8'h04, 0);
    chk("ev hs", 32'h0000_0015, rd);
    u_peer.ctl(4'h0, 1);
    u_peer.line(1, 1, 0, 170);
    pins("suspend", 4'h1);
    u_peer.line(1, 0, 0, 2400);
    pins("gone", 4'h0);
  endtask
  task automatic t_fix();
    u_peer.ctl(4'h2, 5);
    u_peer.ctl(4'h3, 20);
    pins("fixture", 4'hF);
    ce_n <= 1'b1;
    cyc(8);
    pins("disabled", 4'h0);
    ce_n <= 1'b0;
    cyc(20);
    chk("relatch", 32'h0000_0003, {30'h0, eql});
    pins("fixture again", 4'hF);
    ahb(1, 8'h0C, 32'h0000_0001);
    cyc(2);
    pins("eq off", 4'h7);
    ahb(1, 8'h0C, 32'h0000_0000);
    u_peer.ctl(4'h4, 20);
    pins("hs disc", 4'h0);
  endtask
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    cyc(5000); // Held disabled while the supply settles
    t_regs();
    t_gain();
    t_att(0, 1, 0, 2'h2);
    t_att(1, 0, 1, 2'h1);
    t_hs();
    t_fix();
    close_out();
  end
endmodule // tb
`default_nettype wire
